// ### bench/dcsw_drive_control_bench.sv
// Testbench: command sequences through the object index port, state checks.
// Assumes plant model answers fault reaction and quick stop after 10 cycles.
`timescale 1ns/1ps

module dcsw_drive_control_bench;
	import dcsw_pkg::*;
	// State patterns as {mask, value} over bits 6,5,3..0
	localparam logic [31:0] S_NRDY = {16'h002f, 16'h0000};
	localparam logic [31:0] S_SOD  = {16'h004f, 16'h0040};
	localparam logic [31:0] S_RDY  = {16'h006f, 16'h0021};
	localparam logic [31:0] S_SON  = {16'h006f, 16'h0023};
	localparam logic [31:0] S_OPEN = {16'h006f, 16'h0027};
	localparam logic [31:0] S_QSA  = {16'h006f, 16'h0007};
	localparam logic [31:0] S_FRA  = {16'h004f, 16'h000f};
	localparam logic [31:0] S_FLT  = {16'h004f, 16'h0008};

	logic ref_clk = 0, reset = 1, od_wr = 0, init_done = 0, fault_pin = 0, alarm_nonres = 0;
	logic warn_in = 0, main_supply_pin = 0, comm_above_pre_operational_state = 0, target_reached = 0, lim_enable = 0;
	logic [15:0] od_index = 0, od_wdata = 0, od_rdata_r, state_word_r;
	logic [2:0]  qs_option = 0, halt_option = 3'h5, mode_status = 0, halt_mode_r;
	logic [7:0]  op_mode = 0;
	logic [31:0] pos_target = 0, lim_min = 0, lim_max = 0, lim_target_r;
	logic react_done, stop_done, volt_en_r, op_en_r, qstop_r, halt_r, homing_start_r, fault_clear_r;
	logic [3:0]  mode_ctrl_r;
	int error_cnt = 0, checks = 0, clr_cnt = 0, c0;

	always #5 ref_clk = ~ref_clk;

	dcsw_drive_control dut (.ref_clk(ref_clk), .reset(reset), .od_index(od_index), .od_wr(od_wr),
		.od_wdata(od_wdata), .od_rdata_r(od_rdata_r), .state_word_r(state_word_r),
		.init_done(init_done), .fault_pin(fault_pin), .alarm_nonres(alarm_nonres),
		.warn_in(warn_in), .react_done(react_done), .stop_done(stop_done), .qs_option(qs_option),
		.halt_option(halt_option), .op_mode(op_mode), .main_supply_pin(main_supply_pin),
		.comm_above_pre_operational_state(comm_above_pre_operational_state), .target_reached(target_reached),
		.mode_status(mode_status), .lim_enable(lim_enable), .pos_target(pos_target),
		.lim_min(lim_min), .lim_max(lim_max), .lim_target_r(lim_target_r), .volt_en_r(volt_en_r),
		.op_en_r(op_en_r), .qstop_r(qstop_r), .halt_r(halt_r), .halt_mode_r(halt_mode_r),
		.homing_start_r(homing_start_r), .mode_ctrl_r(mode_ctrl_r), .fault_clear_r(fault_clear_r));

	dcsw_plant_model #(.DELAY(10)) plant (.ref_clk(ref_clk), .reset(reset), .qstop_r(qstop_r),
		.state_word_r(state_word_r), .react_done(react_done), .stop_done(stop_done));

	// Count accepted fault reset pulses
	always @(posedge ref_clk) if (fault_clear_r === 1'b1) clr_cnt++;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic st(input string nm, input logic [31:0] s);
		chk(nm, {16'h0, s[15:0]}, {16'h0, state_word_r & s[31:16]});
	endtask

	task automatic wri(input logic [15:0] idx, input logic [15:0] d);
		@(negedge ref_clk);
		od_index = idx;
		od_wdata = d;
		od_wr    = 1'b1;
		@(negedge ref_clk);
		od_wr    = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic wr(input logic [15:0] d);
		wri(DCSW_IDX_CMD, d);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
		@(negedge ref_clk);
		od_index = idx;
		repeat (2) @(negedge ref_clk);
		chk("rdata", {16'h0, exp}, {16'h0, od_rdata_r});
	endtask

	task automatic final_report;
		if (error_cnt == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog for a hung sequence
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end

	initial begin
		repeat (8) @(negedge ref_clk);
		chk("reset word", 32'h0, {16'h0, state_word_r});
		reset = 1'b0;
		repeat (3) @(negedge ref_clk);
		st("not ready", S_NRDY);
		wr(16'h0007);
		st("nrdy hold", S_NRDY);
		init_done = 1'b1;
		main_supply_pin = 1'b1;
		comm_above_pre_operational_state = 1'b1;
		repeat (5) @(negedge ref_clk);
		st("sod", S_SOD);
		chk("volt bit", 32'h1, 32'(state_word_r[DCSW_SB_VOLT]));
		chk("remote", 32'h1, 32'(state_word_r[DCSW_SB_REMOTE]));
		wr(16'h0007);
		st("sod hold", S_SOD);
		wr(16'hfc06);
		st("ready", S_RDY);
		wr(16'h0007);
		st("switched on", S_SON);
		wr(16'h000f);
		st("open", S_OPEN);
		chk("op_en", 32'h1, 32'(op_en_r));
		chk("volt_en", 32'h1, 32'(volt_en_r));
		wr(16'h0007);
		st("disable op", S_SON);
		wr(16'h0006);
		st("son to rdy", S_RDY);
		wr(16'h000f);
		st("rdy 3+4", S_OPEN);
		wr(16'h0006);
		st("open to rdy", S_RDY);
		wr(16'h0000);
		st("rdy to sod", S_SOD);
		wr(16'h0006);
		wr(16'h000f);
		wr(16'h0000);
		st("open to sod", S_SOD);
		wr(16'h0007);
		wr(16'h0006);
		wr(16'h0007);
		wr(16'h0001);
		st("son to sod", S_SOD);
		wr(16'h0006);
		wr(16'h000f);
		wr(16'h000b);
		st("quick stop", S_QSA);
		chk("qstop", 32'h1, 32'(qstop_r));
		repeat (16) @(negedge ref_clk);
		st("qs auto", S_SOD);
		wr(16'h0006);
		wr(16'h000f);
		op_mode = DCSW_MODE_HOMING;
		wr(16'h001f);
		chk("homing", 32'h1, 32'(homing_start_r));
		chk("mode ctrl", 32'h1, 32'(mode_ctrl_r));
		wr(16'h036f);
		chk("halt", 32'h1, 32'(halt_r));
		chk("halt mode", 32'h5, 32'(halt_mode_r));
		chk("mode ctrl2", 32'he, 32'(mode_ctrl_r));
		st("halt open", S_OPEN);
		rd(DCSW_IDX_CMD, 16'h036f);
		rd(DCSW_IDX_STATE, 16'h0237);
		rd(16'h1234, 16'h0000);
		wri(DCSW_IDX_STATE, 16'h0000);
		st("ro word", S_OPEN);
		target_reached = 1'b1;
		lim_enable = 1'b1;
		lim_max = 32'd1000;
		lim_min = -32'sd1000;
		pos_target = 32'd2000;
		repeat (4) @(negedge ref_clk);
		chk("reached", 32'h1, 32'(state_word_r[DCSW_SB_TREACH]));
		chk("clamp hi", 32'd1000, lim_target_r);
		chk("limit set", 32'h1, 32'(state_word_r[DCSW_SB_LIMIT]));
		pos_target = -32'sd3000;
		repeat (4) @(negedge ref_clk);
		chk("clamp lo", -32'sd1000, lim_target_r);
		pos_target = 32'd500;
		target_reached = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk("unclamp", 32'd500, lim_target_r);
		chk("limit clr", 32'h0, 32'(state_word_r[DCSW_SB_LIMIT]));
		chk("not reached", 32'h0, 32'(state_word_r[DCSW_SB_TREACH]));
		wr(16'h000f);
		fault_pin = 1'b1;
		repeat (6) @(negedge ref_clk);
		st("fault react", S_FRA);
		repeat (16) @(negedge ref_clk);
		st("fault", S_FLT);
		fault_pin = 1'b0;
		alarm_nonres = 1'b1;
		c0 = clr_cnt;
		wr(16'h0000);
		wr(16'h0080);
		st("nonres kept", S_FLT);
		alarm_nonres = 1'b0;
		wr(16'h0000);
		wr(16'h0080);
		repeat (4) @(negedge ref_clk);
		st("fault reset", S_SOD);
		chk("clr pulses", 32'(c0 + 1), 32'(clr_cnt));
		wr(16'h0086);
		st("bit7 held", S_SOD);
		chk("clr once", 32'(c0 + 1), 32'(clr_cnt));
		wr(16'h0006);
		st("after reset", S_RDY);
		warn_in = 1'b1;
		comm_above_pre_operational_state = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk("warning", 32'h1, 32'(state_word_r[DCSW_SB_WARN]));
		chk("remote off", 32'h0, 32'(state_word_r[DCSW_SB_REMOTE]));
		final_report();
	end
endmodule // dcsw_drive_control_bench

// ### bench/dcsw_plant_model.sv
// Drive-side plant model: finishes fault reaction and quick-stop braking.
// Assumes it watches the state word and quick-stop level of the interpreter.
`timescale 1ns/1ps

module dcsw_plant_model #(
	parameter int DELAY = 10
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        qstop_r,
	input  wire logic [15:0] state_word_r,
	output logic             react_done,
	output logic             stop_done
);
	logic       fra;
	logic [7:0] cnt;

	// Fault reaction shows as low nibble 1111
	assign fra = (state_word_r[3:0] == 4'hf);

	// Slow answer: each activity takes DELAY cycles
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt        <= 8'h00;
			react_done <= 1'b0;
			stop_done  <= 1'b0;
		end else begin
			cnt        <= (fra | qstop_r) ? ((cnt == 8'(DELAY)) ? cnt : cnt + 8'h01) : 8'h00;
			react_done <= fra && (cnt == 8'(DELAY));
			stop_done  <= qstop_r && (cnt == 8'(DELAY));
		end
	end
endmodule // dcsw_plant_model

// ### core/dcsw_drive_control.sv
// Drive command word decoder, power-drive state machine and state word.
// Assumes the fieldbus side writes the command word by object index on
// ref_clk; drive-side status inputs are on ref_clk except fault and main
// supply pins, which are synchronised here.
//
// How it works
// RULE_01 - Bits 0,1,3 active high; bit 2 low
// RULE_02 - Bits 0-3,7 decoded only as patterns
// RULE_03 - Shutdown: transitions 2,6,8; switch-on: 3
// RULE_04 - Enable op: 4,16; from ready 3+4
// RULE_05 - Disable voltage, quick stop, disable operation
// RULE_06 - Bit 7 rising edge leaves fault
// RULE_07 - Bit 7 held high blocks other commands
// RULE_08 - Fault reset clears resettable alarms only
// RULE_09 - Bit 8 requests halt per option
// RULE_10 - Bits 4-6,9 mode-specific; homing start
// RULE_11 - Control 10-15, status 8 reserved
// RULE_12 - Status bits 0-7 positions fixed
// RULE_13 - Status bit 9 reports remote control
// RULE_14 - Status bit 10 reports target reached
// RULE_15 - Status bit 11 flags software limit
// RULE_16 - Limit value substitutes target at limit
// RULE_17 - Reverse command leaves limit, clears flag
// RULE_18 - State encoded in status bits 6,5,3-0
// RULE_19 - Drive failure forces fault reaction
// RULE_20 - Quick stop options 0-3 auto-disable
// RULE_21 - Remote set above pre-operational state
// RULE_22 - Previous bit 7 captured every cycle
// RULE_23 - Unmatched pattern keeps present state
`timescale 1ns/1ps

module dcsw_drive_control
	import dcsw_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [15:0] od_index,
	input  wire logic        od_wr,
	input  wire logic [15:0] od_wdata,
	output logic      [15:0] od_rdata_r,
	output logic      [15:0] state_word_r,
	input  wire logic        init_done,
	input  wire logic        fault_pin,
	input  wire logic        alarm_nonres,
	input  wire logic        warn_in,
	input  wire logic        react_done,
	input  wire logic        stop_done,
	input  wire logic [2:0]  qs_option,
	input  wire logic [2:0]  halt_option,
	input  wire logic [7:0]  op_mode,
	input  wire logic        main_supply_pin,
	input  wire logic        comm_above_pre_operational_state,
	input  wire logic        target_reached,
	input  wire logic [2:0]  mode_status,
	input  wire logic        lim_enable,
	input  wire logic [31:0] pos_target,
	input  wire logic [31:0] lim_min,
	input  wire logic [31:0] lim_max,
	output logic      [31:0] lim_target_r,
	output logic             volt_en_r,
	output logic             op_en_r,
	output logic             qstop_r,
	output logic             halt_r,
	output logic      [2:0]  halt_mode_r,
	output logic             homing_start_r,
	output logic      [3:0]  mode_ctrl_r,
	output logic             fault_clear_r
);

	// Command pattern decoders on bits 3..0
	function automatic logic is_shutdown(input logic [15:0] c);
		return c[DCSW_CB_QSTOP] & c[DCSW_CB_VOLT] & ~c[DCSW_CB_SWON]; // RULE_03
	endfunction
	function automatic logic is_switch_on(input logic [15:0] c);
		return ~c[DCSW_CB_ENOP] & c[DCSW_CB_QSTOP] & c[DCSW_CB_VOLT] & c[DCSW_CB_SWON]; // RULE_01
	endfunction
	function automatic logic is_enable_op(input logic [15:0] c);
		return c[DCSW_CB_ENOP] & c[DCSW_CB_QSTOP] & c[DCSW_CB_VOLT] & c[DCSW_CB_SWON]; // RULE_01
	endfunction
	function automatic logic is_dis_volt(input logic [15:0] c);
		return ~c[DCSW_CB_VOLT];
	endfunction
	function automatic logic is_qstop(input logic [15:0] c);
		return ~c[DCSW_CB_QSTOP] & c[DCSW_CB_VOLT]; // RULE_01
	endfunction

	// State code in status bits 6,5,3..0 (bit 4 is supplied separately)
	function automatic logic [6:0] state_code(input dcsw_state_t s);
		case (s)
			DCSW_NRDY: return 7'h00;
			DCSW_SOD:  return 7'h40;
			DCSW_RDY:  return 7'h21;
			DCSW_SON:  return 7'h23;
			DCSW_OPEN: return 7'h27;
			DCSW_QSA:  return 7'h07;
			DCSW_FRA:  return 7'h0f;
			DCSW_FLT:  return 7'h08;
			default:   return 7'h00;
		endcase
	endfunction

	dcsw_state_t state_r;
	dcsw_state_t state_nxt;
	logic [15:0] cmd_r;
	logic        prev_b7_r;
	logic [1:0]  fault_sync_r;
	logic [1:0]  supply_sync_r;
	logic        flt_r;
	logic        warn_r;
	logic        lim_hi_r;
	logic        lim_lo_r;
	logic        fr_edge;
	logic        cmd_ok;
	logic        rst_ok;

	// Pins into the clock domain
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			fault_sync_r  <= DCSW_SYNC_RST;
			supply_sync_r <= DCSW_SYNC_RST;
		end else begin
			fault_sync_r  <= {fault_sync_r[0], fault_pin};
			supply_sync_r <= {supply_sync_r[0], main_supply_pin};
		end
	end

	// Command word store; the state word index is read-only
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cmd_r <= DCSW_CMD_RST;
		end else if (od_wr && od_index == DCSW_IDX_CMD) begin
			cmd_r <= od_wdata; // RULE_11
		end
	end

	// Fault-reset edge: only a 0-to-1 step counts, and bit 7 held high
	// blocks every other pattern so a stuck reset cannot drive the machine
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prev_b7_r <= 1'b0;
		end else begin
			prev_b7_r <= cmd_r[DCSW_CB_FRST]; // RULE_22
		end
	end
	assign fr_edge = cmd_r[DCSW_CB_FRST] & ~prev_b7_r; // RULE_06
	assign cmd_ok  = ~cmd_r[DCSW_CB_FRST]; // RULE_07
	assign rst_ok  = fr_edge & ~alarm_nonres; // RULE_08

	// Alarm latches; a new alarm wins over a reset in the same cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flt_r  <= 1'b0;
			warn_r <= 1'b0;
		end else begin
			flt_r  <= fault_sync_r[1] | (flt_r & ~rst_ok); // RULE_08
			warn_r <= warn_in | (warn_r & ~rst_ok); // RULE_08
		end
	end

	// Next state from the combined command pattern
	always_comb begin
		state_nxt = state_r; // RULE_23
		if (flt_r && state_r != DCSW_FRA && state_r != DCSW_FLT) begin
			state_nxt = DCSW_FRA; // RULE_19
		end else begin
			case (state_r)
				DCSW_NRDY: begin
					if (init_done) state_nxt = DCSW_SOD;
				end
				DCSW_SOD: begin
					if (cmd_ok && is_shutdown(cmd_r)) state_nxt = DCSW_RDY; // RULE_03
				end
				DCSW_RDY: begin
					if (cmd_ok) begin // RULE_02
						if (is_dis_volt(cmd_r) || is_qstop(cmd_r)) state_nxt = DCSW_SOD; // RULE_05
						else if (is_switch_on(cmd_r) || is_enable_op(cmd_r)) state_nxt = DCSW_SON; // RULE_04
					end
				end
				DCSW_SON: begin
					if (cmd_ok) begin
						if (is_dis_volt(cmd_r) || is_qstop(cmd_r)) state_nxt = DCSW_SOD; // RULE_05
						else if (is_shutdown(cmd_r)) state_nxt = DCSW_RDY; // RULE_03
						else if (is_enable_op(cmd_r)) state_nxt = DCSW_OPEN; // RULE_04
					end
				end
				DCSW_OPEN: begin
					if (cmd_ok) begin
						if (is_dis_volt(cmd_r)) state_nxt = DCSW_SOD; // RULE_05
						else if (is_qstop(cmd_r)) state_nxt = DCSW_QSA; // RULE_05
						else if (is_shutdown(cmd_r)) state_nxt = DCSW_RDY; // RULE_03
						else if (is_switch_on(cmd_r)) state_nxt = DCSW_SON; // RULE_05
					end
				end
				DCSW_QSA: begin
					if (cmd_ok && is_dis_volt(cmd_r)) state_nxt = DCSW_SOD; // RULE_05
					else if (stop_done && qs_option <= DCSW_QS_AUTO_MAX) state_nxt = DCSW_SOD; // RULE_20
					else if (cmd_ok && is_enable_op(cmd_r) && qs_option > DCSW_QS_AUTO_MAX) begin
						state_nxt = DCSW_OPEN; // RULE_04
					end
				end
				DCSW_FRA: begin
					if (react_done) state_nxt = DCSW_FLT;
				end
				DCSW_FLT: begin
					if (rst_ok) state_nxt = DCSW_SOD; // RULE_06
				end
				default: state_nxt = DCSW_NRDY;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= DCSW_NRDY;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Software position limit: clamp the target and flag it until a
	// command in the reverse direction moves back inside the range
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lim_hi_r     <= 1'b0;
			lim_lo_r     <= 1'b0;
			lim_target_r <= DCSW_POS_RST;
		end else begin
			lim_hi_r <= lim_enable && ($signed(pos_target) >= $signed(lim_max)); // RULE_15 RULE_17
			lim_lo_r <= lim_enable && ($signed(pos_target) <= $signed(lim_min)); // RULE_15 RULE_17
			if (lim_enable && $signed(pos_target) >= $signed(lim_max)) begin
				lim_target_r <= lim_max; // RULE_16
			end else if (lim_enable && $signed(pos_target) <= $signed(lim_min)) begin
				lim_target_r <= lim_min; // RULE_16
			end else begin
				lim_target_r <= pos_target;
			end
		end
	end

	// State word assembly, one cycle behind the state register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_word_r <= DCSW_STATE_RST;
		end else begin
			state_word_r                  <= {9'h000, state_code(state_r)}; // RULE_12 RULE_18
			state_word_r[DCSW_SB_VOLT]    <= supply_sync_r[1];
			state_word_r[DCSW_SB_WARN]    <= warn_r;
			state_word_r[DCSW_SB_REMOTE]  <= comm_above_pre_operational_state; // RULE_13 RULE_21
			state_word_r[DCSW_SB_TREACH]  <= target_reached; // RULE_14
			state_word_r[DCSW_SB_LIMIT]   <= lim_hi_r | lim_lo_r; // RULE_15
			state_word_r[DCSW_SB_MODE12+:2] <= mode_status[1:0];
			state_word_r[DCSW_SB_HOMED]   <= mode_status[2];
		end
	end

	// Object read port; unknown indices read zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			od_rdata_r <= DCSW_CMD_RST;
		end else if (od_index == DCSW_IDX_CMD) begin
			od_rdata_r <= cmd_r;
		end else if (od_index == DCSW_IDX_STATE) begin
			od_rdata_r <= state_word_r;
		end else begin
			od_rdata_r <= DCSW_CMD_RST;
		end
	end

	// Drive enables, halt and mode-specific controls
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			volt_en_r      <= 1'b0;
			op_en_r        <= 1'b0;
			qstop_r        <= 1'b0;
			halt_r         <= 1'b0;
			halt_mode_r    <= 3'h0;
			homing_start_r <= 1'b0;
			mode_ctrl_r    <= 4'h0;
			fault_clear_r  <= 1'b0;
		end else begin
			volt_en_r      <= state_r == DCSW_SON || state_r == DCSW_OPEN || state_r == DCSW_QSA;
			op_en_r        <= state_r == DCSW_OPEN;
			qstop_r        <= state_r == DCSW_QSA;
			halt_r         <= cmd_r[DCSW_CB_HALT] && state_r == DCSW_OPEN; // RULE_09
			halt_mode_r    <= halt_option; // RULE_09
			homing_start_r <= cmd_r[DCSW_CB_HOME] && op_mode == DCSW_MODE_HOMING
				&& state_r == DCSW_OPEN; // RULE_10
			mode_ctrl_r    <= {cmd_r[DCSW_CB_MODE9], cmd_r[6:4]}; // RULE_10
			fault_clear_r  <= rst_ok; // RULE_08
		end
	end

	default clocking dcsw_cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	fault_entry_a: assert property (flt_r && state_r != DCSW_FRA && state_r != DCSW_FLT |=> state_r == DCSW_FRA) // RULE_19
		else $error("alarm did not enter fault reaction");
	fault_exit_a: assert property (state_r == DCSW_FLT && fr_edge && !alarm_nonres |=> state_r == DCSW_SOD) // RULE_06
		else $error("fault reset edge did not leave fault");
	nonres_hold_a: assert property (state_r == DCSW_FLT && alarm_nonres |=> state_r == DCSW_FLT) // RULE_08
		else $error("non-resettable fault was cleared");
	b7_block_a: assert property (cmd_r[DCSW_CB_FRST] && !flt_r // RULE_07
		&& (state_r == DCSW_SOD || state_r == DCSW_OPEN) |=> state_r == $past(state_r))
		else $error("command acted while bit 7 held");
	qstop_entry_a: assert property (state_r == DCSW_OPEN && cmd_ok && is_qstop(cmd_r) && !flt_r // RULE_05
		|=> state_r == DCSW_QSA ##1 qstop_r)
		else $error("quick stop not entered");
	auto_enable_a: assert property (state_r == DCSW_RDY && cmd_ok && is_enable_op(cmd_r) && !flt_r // RULE_04
		##1 (cmd_ok && is_enable_op(cmd_r) && !flt_r) |=> state_r == DCSW_OPEN)
		else $error("ready did not continue to operation enabled");
	qs_auto_a: assert property (state_r == DCSW_QSA && stop_done && qs_option <= DCSW_QS_AUTO_MAX // RULE_20
		&& !flt_r |=> state_r == DCSW_SOD ##1 {state_word_r[6:5], state_word_r[3:0]} == 6'h20)
		else $error("quick stop did not fall back");
	open_code_a: assert property (state_r == DCSW_OPEN |=> {state_word_r[6:5], state_word_r[3:0]} == 6'h17) // RULE_18
		else $error("operation enabled code wrong");
	remote_bit_a: assert property (!$past(reset) |-> state_word_r[DCSW_SB_REMOTE] == $past(comm_above_pre_operational_state)) // RULE_13
		else $error("remote bit does not follow link state");
	limit_clamp_a: assert property (lim_hi_r |-> lim_target_r == $past(lim_max) // RULE_16
		##1 state_word_r[DCSW_SB_LIMIT])
		else $error("limit clamp or flag wrong");

endmodule // dcsw_drive_control

// ### pkg/dcsw_pkg.sv
// Constants and types for the drive command and state word interpreter.
// Assumes a single control clock and a power-on reset in the drive.
package dcsw_pkg;

	// Object dictionary indices of the two words
	localparam logic [15:0] DCSW_IDX_CMD    = 16'h6040;
	localparam logic [15:0] DCSW_IDX_STATE  = 16'h6041;

	// Values after reset
	localparam logic [15:0] DCSW_CMD_RST    = 16'h0000;
	localparam logic [15:0] DCSW_STATE_RST  = 16'h0000;
	localparam logic [31:0] DCSW_POS_RST    = 32'h0000_0000;
	localparam logic [1:0]  DCSW_SYNC_RST   = 2'h0;

	// Command word bit positions
	localparam int DCSW_CB_SWON   = 0;
	localparam int DCSW_CB_VOLT   = 1;
	localparam int DCSW_CB_QSTOP  = 2;
	localparam int DCSW_CB_ENOP   = 3;
	localparam int DCSW_CB_HOME   = 4;
	localparam int DCSW_CB_FRST   = 7;
	localparam int DCSW_CB_HALT   = 8;
	localparam int DCSW_CB_MODE9  = 9;

	// State word bit positions
	localparam int DCSW_SB_VOLT   = 4;
	localparam int DCSW_SB_WARN   = 7;
	localparam int DCSW_SB_REMOTE = 9;
	localparam int DCSW_SB_TREACH = 10;
	localparam int DCSW_SB_LIMIT  = 11;
	localparam int DCSW_SB_MODE12 = 12;
	localparam int DCSW_SB_HOMED  = 15;

	// Quick-stop option codes up to this value fall back to switch-on disabled
	localparam logic [2:0]  DCSW_QS_AUTO_MAX = 3'h3;
	// Operating mode code of homing_mode
	localparam logic [7:0]  DCSW_MODE_HOMING = 8'h06;

	// Power-drive states, one-hot
	typedef enum logic [7:0] {
		DCSW_NRDY = 8'h01,
		DCSW_SOD  = 8'h02,
		DCSW_RDY  = 8'h04,
		DCSW_SON  = 8'h08,
		DCSW_OPEN = 8'h10,
		DCSW_QSA  = 8'h20,
		DCSW_FRA  = 8'h40,
		DCSW_FLT  = 8'h80
	} dcsw_state_t;

endpackage
